// ### core/wwdg_pkg.sv
// Package: register map, field layout, reset values and types of the watchdog
package wwdg_pkg;

  // Register byte offsets
  localparam logic [3:0] WWDG_OFS_CTRL = 4'h0;
  localparam logic [3:0] WWDG_OFS_CFG  = 4'h4;
  localparam logic [3:0] WWDG_OFS_STAT = 4'h8;

  // Field positions
  localparam int WWDG_RUN_BIT    = 7;
  localparam int WWDG_IRQEN_BIT  = 9;
  localparam int WWDG_DIV_LSB    = 7;
  localparam int WWDG_FLAG_BIT   = 0;
  localparam int WWDG_CNT_W      = 7;

  // Reset values
  localparam logic [6:0] WWDG_CNT_RST = 7'h7F;
  localparam logic [6:0] WWDG_WIN_RST = 7'h7F;
  localparam logic [1:0] WWDG_DIV_RST = 2'h0;

  // Counter thresholds
  localparam logic [6:0] WWDG_CNT_WARN = 7'h40;

  // Base prescale of the bus clock
  localparam int WWDG_BASE_DIV = 4096;

  // Pulse length of the reset request, in clock cycles
  localparam int WWDG_RST_PULSE = 1;

  // Classic Wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wwdg_wb_req_t;

  // Classic Wishbone answer
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] dat;
  } wwdg_wb_rsp_t;

  // One register access as seen by the core logic
  typedef struct packed {
    logic        wr_ctrl;
    logic        wr_cfg;
    logic        wr_stat;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wwdg_wr_t;

endpackage : wwdg_pkg

// ### core/wwdg_tick.sv
// Prescaler: bus clock divided by 4096 and then by 1, 2, 4 or 8
`timescale 1ns/1ns
module wwdg_tick
  import wwdg_pkg::*;
#(
  parameter int BASE_DIV = WWDG_BASE_DIV
)
(
  input  wire logic       clk_sys,  // Bus clock
  input  wire logic       rstn,     // Async reset, active low
  input  wire logic       run,      // Counting allowed
  input  wire logic [1:0] div_sel,  // Extra divider code
  output logic            tick      // One-cycle counter step
);

  localparam int BW = $clog2(BASE_DIV);

  logic [BW-1:0] base_q;
  logic [2:0]    post_q;
  logic          base_end;
  logic [2:0]    post_lim;

  assign base_end = (base_q == BW'(BASE_DIV - 1));
  assign post_lim = 3'((1 << div_sel) - 1);

  // Base divider stops with the counter so a paused counter stays exact
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      base_q <= '0;
    else if (run)
      base_q <= base_end ? '0 : base_q + BW'(1);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      post_q <= 3'h0;
    else if (run && base_end)
      post_q <= (post_q >= post_lim) ? 3'h0 : post_q + 3'h1;
  end

  assign tick = run && base_end && (post_q >= post_lim);

endmodule : wwdg_tick

// ### core/wwdg_wb_slave.sv
// Classic Wishbone slave front end for the watchdog registers
`timescale 1ns/1ns
module wwdg_wb_slave
  import wwdg_pkg::*;
(
  input  wire logic         clk_sys,  // Bus clock
  input  wire logic         rstn,     // Async reset, active low
  input  wire wwdg_wb_req_t wb_req,   // Bus request
  output wwdg_wb_rsp_t      wb_rsp,   // Bus answer
  input  wire logic [31:0]  rd_ctrl,  // Control readback
  input  wire logic [31:0]  rd_cfg,   // Config readback
  input  wire logic [31:0]  rd_stat,  // Status readback
  output wwdg_wr_t          wr        // One-cycle write strobes
);

  logic        ack_q;
  logic        err_q;
  logic [31:0] dat_q;
  logic        req;
  logic        hit;

  assign req = wb_req.cyc && wb_req.stb && !ack_q && !err_q;
  assign hit = (wb_req.adr == WWDG_OFS_CTRL) ||
               (wb_req.adr == WWDG_OFS_CFG)  ||
               (wb_req.adr == WWDG_OFS_STAT);

  // Answer one cycle after the request, then drop for one cycle
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      ack_q <= req && hit;
      err_q <= req && !hit;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      dat_q <= 32'h0000_0000;
    else if (req && !wb_req.we)
    begin
      case (wb_req.adr)
        WWDG_OFS_CTRL: dat_q <= rd_ctrl;
        WWDG_OFS_CFG:  dat_q <= rd_cfg;
        WWDG_OFS_STAT: dat_q <= rd_stat;
        default:       dat_q <= 32'h0000_0000;
      endcase
    end
  end

  // Write takes effect at the edge where ack is sampled
  always_comb
  begin
    wr.sel     = wb_req.sel;
    wr.dat     = wb_req.dat;
    wr.wr_ctrl = ack_q && wb_req.we && (wb_req.adr == WWDG_OFS_CTRL);
    wr.wr_cfg  = ack_q && wb_req.we && (wb_req.adr == WWDG_OFS_CFG);
    wr.wr_stat = ack_q && wb_req.we && (wb_req.adr == WWDG_OFS_STAT);
  end

  assign wb_rsp.ack = ack_q;
  assign wb_rsp.err = err_q;
  assign wb_rsp.dat = dat_q;

endmodule : wwdg_wb_slave

// ### core/wwdg_core.sv
// Window watchdog top: registers, down counter, reset and warning logic
//
// Summary of operation
// - Seven-bit counter steps down per tick
// - Reset request when counter leaves 0x40
// - Reset request on refresh above window
// - Run bit set-only, cleared by reset
// - Tick is clock/4096 then /1,/2,/4,/8
// - Warning flag at 0x40 or early refresh
// - Writing zero clears flag, one ignored
// - Interrupt output when enabled and flagged
// - Interrupt enable set-only, bus reset clears
// - Debug freeze stops counting while halted
// - Counter field reads live, write loads
// - Config holds seven-bit window limit
// - Control and config reset to 0x7F
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module wwdg_core
  import wwdg_pkg::*;
#(
  parameter int BASE_DIV = WWDG_BASE_DIV
)
(
  input  wire logic         clk_sys,        // Bus clock, 100 MHz
  input  wire logic         rstn,           // Async reset, active low
  input  wire logic         bus_rst,        // Peripheral bus reset, sync
  input  wire wwdg_wb_req_t wb_req,         // Wishbone request
  output wwdg_wb_rsp_t      wb_rsp,         // Wishbone answer
  input  wire logic         debug_freeze,   // Freeze control from debug
  input  wire logic         core_halted,    // Core halted, async pin
  output logic              sys_rst_req,    // System reset request pulse
  output logic              early_warn_irq  // Early warning interrupt
);

  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic [6:0]  count_value_q;
  logic        watchdog_run_q;
  logic [6:0]  window_limit_q;
  logic [1:0]  tick_divider_select_q;
  logic        early_warn_irq_enable_q;
  logic        early_warn_flag_q;
  logic        rst_req_q;
  logic        irq_q;
  logic [1:0]  halt_sync_q;
  logic        halted;
  logic        tick;
  logic        count_run;
  logic        load_cnt;
  logic        early_load;
  logic        reach_warn;
  logic        fall_out;
  logic        flag_clr;
  wwdg_wr_t    wr;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_cfg;
  logic [31:0] rd_stat;

  // Byte lane 0 and lane 1 write enables
  function automatic logic lane_we(input logic [3:0] sel, input int lane);
    lane_we = sel[lane];
  endfunction : lane_we

  // --------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------
  wwdg_wb_slave u_bus (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .wb_req  (wb_req),
    .wb_rsp  (wb_rsp),
    .rd_ctrl (rd_ctrl),
    .rd_cfg  (rd_cfg),
    .rd_stat (rd_stat),
    .wr      (wr)
  );

  assign rd_ctrl = {24'h000000, watchdog_run_q, count_value_q};
  assign rd_cfg  = {22'h000000, early_warn_irq_enable_q,
                    tick_divider_select_q, window_limit_q};
  assign rd_stat = {31'h00000000, early_warn_flag_q};

  // --------------------------------------------------------------------
  // Debug halt synchroniser
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      halt_sync_q <= 2'b00;
    else
      halt_sync_q <= {halt_sync_q[0], core_halted};
  end

  assign halted = halt_sync_q[1];

  // --------------------------------------------------------------------
  // Time base
  // --------------------------------------------------------------------
  assign count_run = watchdog_run_q && !(debug_freeze && halted);

  wwdg_tick #(
    .BASE_DIV (BASE_DIV)
  ) u_tick (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (count_run),
    .div_sel (tick_divider_select_q),
    .tick    (tick)
  );

  // --------------------------------------------------------------------
  // Control register: run bit and counter
  // --------------------------------------------------------------------
  assign load_cnt = wr.wr_ctrl && lane_we(wr.sel, 0);

  // Set-only run bit
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      watchdog_run_q <= 1'b0;
    else if (load_cnt && wr.dat[WWDG_RUN_BIT])
      watchdog_run_q <= 1'b1;
  end

  // Counter: software load wins over a tick in the same cycle
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      count_value_q <= WWDG_CNT_RST;
    else if (load_cnt)
      count_value_q <= wr.dat[WWDG_CNT_W-1:0];
    else if (tick)
      count_value_q <= count_value_q - 7'h01;
  end

  // --------------------------------------------------------------------
  // Configuration register
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      window_limit_q        <= WWDG_WIN_RST;
      tick_divider_select_q <= WWDG_DIV_RST;
    end
    else if (wr.wr_cfg)
    begin
      if (lane_we(wr.sel, 0))
      begin
        window_limit_q           <= wr.dat[6:0];
        tick_divider_select_q[0] <= wr.dat[WWDG_DIV_LSB];
      end
      if (lane_we(wr.sel, 1))
        tick_divider_select_q[1] <= wr.dat[WWDG_DIV_LSB+1];
    end
  end

  // Set-only enable, also cleared by the peripheral bus reset
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      early_warn_irq_enable_q <= 1'b0;
    else if (bus_rst)
      early_warn_irq_enable_q <= 1'b0;
    else if (wr.wr_cfg && lane_we(wr.sel, 1) && wr.dat[WWDG_IRQEN_BIT])
      early_warn_irq_enable_q <= 1'b1;
  end

  // --------------------------------------------------------------------
  // Event detection
  // --------------------------------------------------------------------
  assign early_load = watchdog_run_q && load_cnt &&
                      (count_value_q > window_limit_q);
  assign reach_warn = tick && !load_cnt &&
                      (count_value_q == WWDG_CNT_WARN + 7'h01);
  assign fall_out   = tick && !load_cnt &&
                      (count_value_q == WWDG_CNT_WARN);

  // --------------------------------------------------------------------
  // Early warning flag: hardware set wins over software clear
  // --------------------------------------------------------------------
  assign flag_clr = wr.wr_stat && lane_we(wr.sel, 0) &&
                    !wr.dat[WWDG_FLAG_BIT];

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      early_warn_flag_q <= 1'b0;
    else if (reach_warn || early_load)
      early_warn_flag_q <= 1'b1;
    else if (flag_clr)
      early_warn_flag_q <= 1'b0;
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rst_req_q <= 1'b0;
    else
      rst_req_q <= watchdog_run_q && (fall_out || early_load);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      irq_q <= 1'b0;
    else
      irq_q <= early_warn_irq_enable_q && early_warn_flag_q;
  end

  assign sys_rst_req    = rst_req_q;
  assign early_warn_irq = irq_q;

endmodule : wwdg_core

// ### bench/wwdg_core_props.sv
// Checker: bus, reset request and interrupt properties of the watchdog
`timescale 1ns/1ns
module wwdg_core_props
  import wwdg_pkg::*;
#(
  parameter int BASE_DIV = WWDG_BASE_DIV
)
(
  input wire logic         clk_sys,        // Bus clock
  input wire logic         rstn,           // Async reset, active low
  input wire logic         bus_rst,        // Bus reset
  input wire wwdg_wb_req_t wb_req,         // Bus request
  input wire wwdg_wb_rsp_t wb_rsp,         // Bus answer
  input wire logic         debug_freeze,   // Freeze control
  input wire logic         core_halted,    // Core halted
  input wire logic         sys_rst_req,    // Reset request
  input wire logic         early_warn_irq  // Warning interrupt
);
  // ----------------------------------------
  // Shadow of the set-only bits
  // ----------------------------------------
  logic run_q;
  logic irq_en_q;
  logic wr_ok;
  assign wr_ok = wb_req.cyc && wb_req.stb && wb_req.we && wb_rsp.ack;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      run_q <= 1'b0;
    else if (wr_ok && wb_req.adr == WWDG_OFS_CTRL && wb_req.sel[0]
             && wb_req.dat[WWDG_RUN_BIT])
      run_q <= 1'b1;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      irq_en_q <= 1'b0;
    else if (bus_rst)
      irq_en_q <= 1'b0;
    else if (wr_ok && wb_req.adr == WWDG_OFS_CFG && wb_req.sel[1]
             && wb_req.dat[WWDG_IRQEN_BIT])
      irq_en_q <= 1'b1;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_req;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack && !wb_rsp.err;
  endsequence
  sequence s_rd(logic [3:0] a);
    s_req ##0 (!wb_req.we && wb_req.adr == a);
  endsequence

  a_bus_answer: assert property (s_req |=> wb_rsp.ack || wb_rsp.err)
    else $error("no answer one cycle after request");
  a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack longer than one cycle");
  a_err_unmapped: assert property (s_req ##0 (wb_req.adr != WWDG_OFS_CTRL
    && wb_req.adr != WWDG_OFS_CFG && wb_req.adr != WWDG_OFS_STAT)
    |=> wb_rsp.err && !wb_rsp.ack)
    else $error("unmapped access not refused");
  a_rst_pulse: assert property (sys_rst_req |=> !sys_rst_req)
    else $error("reset request longer than one cycle");
  a_rst_running: assert property (sys_rst_req |-> run_q)
    else $error("reset request while stopped");
  a_irq_enabled: assert property (early_warn_irq |-> $past(irq_en_q))
    else $error("interrupt without enable");
  a_irq_busrst: assert property (bus_rst |-> ##2 !early_warn_irq)
    else $error("interrupt survives bus reset");
  a_ctrl_reserved: assert property (s_rd(WWDG_OFS_CTRL)
    |=> wb_rsp.dat[31:8] == 24'h0)
    else $error("control upper bits not zero");
  a_cfg_reserved: assert property (s_rd(WWDG_OFS_CFG)
    |=> wb_rsp.dat[31:10] == 22'h0)
    else $error("config upper bits not zero");
  a_stat_reserved: assert property (s_rd(WWDG_OFS_STAT)
    |=> wb_rsp.dat[31:1] == 31'h0)
    else $error("status upper bits not zero");
endmodule : wwdg_core_props

bind wwdg_core wwdg_core_props #(.BASE_DIV(BASE_DIV)) wwdg_core_props_i (
  .clk_sys(clk_sys), .rstn(rstn), .bus_rst(bus_rst), .wb_req(wb_req),
  .wb_rsp(wb_rsp), .debug_freeze(debug_freeze), .core_halted(core_halted),
  .sys_rst_req(sys_rst_req), .early_warn_irq(early_warn_irq));

// ### bench/wwdg_core_bench.sv
// Testbench: register access, tick rate, warning and reset requests
`timescale 1ns/1ns
module wwdg_core_bench
  import wwdg_pkg::*;
;
  localparam int BD = 16;
  logic         clk_sys = 1'b0;
  logic         rstn = 1'b0;
  logic         bus_rst = 1'b0;
  logic         debug_freeze = 1'b0;
  logic         core_halted = 1'b0;
  wwdg_wb_req_t req = '0;
  wwdg_wb_rsp_t rsp;
  logic         sys_rst_req;
  logic         early_warn_irq;
  logic [31:0]  rd;
  logic         last_err;
  int           error_cnt = 0;
  int           total_checks = 0;
  int           rst_cnt = 0;

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (sys_rst_req === 1'b1)
      rst_cnt++;

  wwdg_core #(.BASE_DIV(BD)) wwdg_core_i (
    .clk_sys(clk_sys), .rstn(rstn), .bus_rst(bus_rst), .wb_req(req),
    .wb_rsp(rsp), .debug_freeze(debug_freeze), .core_halted(core_halted),
    .sys_rst_req(sys_rst_req), .early_warn_irq(early_warn_irq));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp,
             input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: %s", $time, msg);
      error_cnt++;
    end
  endtask : check

  task summarize;
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    req.cyc <= 1'b1;
    req.stb <= 1'b1;
    req.we  <= w;
    req.adr <= a;
    req.sel <= 4'hF;
    req.dat <= d;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (rsp.ack !== 1'b1 && rsp.err !== 1'b1 && n < 50);
    if (n >= 50)
      check(32'h0, 32'h1, "bus timeout");
    rd = rsp.dat;
    last_err = rsp.err;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask : wb

  task do_reset;
    rstn <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    rst_cnt = 0;
  endtask : do_reset

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset_vals;
    do_reset;
    wb(WWDG_OFS_CTRL, 1'b0, 32'h0);
    check(rd, 32'h7F, "ctrl reset");
    wb(WWDG_OFS_CFG, 1'b0, 32'h0);
    check(rd, 32'h7F, "cfg reset");
    wb(WWDG_OFS_STAT, 1'b0, 32'h0);
    check(rd, 32'h0, "stat reset");
    wb(4'hC, 1'b0, 32'h0);
    check({31'h0, last_err}, 32'h1, "unmapped not refused");
    wb(WWDG_OFS_CTRL, 1'b1, 32'h40);
    repeat (4 * BD) @(posedge clk_sys);
    wb(WWDG_OFS_CTRL, 1'b0, 32'h0);
    check(rd, 32'h40, "stopped counter moved");
    check(32'(rst_cnt), 32'h0, "reset while stopped");
  endtask : t_reset_vals

  task t_tick(input logic [1:0] dv);
    do_reset;
    core_halted <= 1'b1;
    wb(WWDG_OFS_CFG, 1'b1, {23'h0, dv, 7'h7F});
    wb(WWDG_OFS_CTRL, 1'b1, 32'hFF);
    repeat (13 * BD * (1 << dv) / 4) @(posedge clk_sys);
    wb(WWDG_OFS_CTRL, 1'b0, 32'h0);
    check(rd, 32'hFC, "tick rate");
  endtask : t_tick

  task t_freeze;
    debug_freeze <= 1'b1;
    repeat (10 * BD) @(posedge clk_sys);
    wb(WWDG_OFS_CTRL, 1'b0, 32'h0);
    check(rd, 32'hFC, "counted while frozen");
    debug_freeze <= 1'b0;
    core_halted <= 1'b0;
  endtask : t_freeze

  task t_warn;
    do_reset;
    wb(WWDG_OFS_CFG, 1'b1, 32'h2FF);
    wb(WWDG_OFS_CTRL, 1'b1, 32'hC1);
    repeat (3 * BD) @(posedge clk_sys);
    check(32'(rst_cnt), 32'h0, "in-window load reset");
    check({31'h0, early_warn_irq}, 32'h1, "no interrupt");
    wb(WWDG_OFS_STAT, 1'b1, 32'h1);
    wb(WWDG_OFS_STAT, 1'b0, 32'h0);
    check(rd, 32'h1, "flag at 0x40");
    wb(WWDG_OFS_STAT, 1'b1, 32'h0);
    wb(WWDG_OFS_STAT, 1'b0, 32'h0);
    check(rd, 32'h0, "flag not cleared");
    check({31'h0, early_warn_irq}, 32'h0, "interrupt stuck");
    repeat (2 * BD) @(posedge clk_sys);
    check(32'(rst_cnt), 32'h1, "no reset at 0x3F");
  endtask : t_warn

  task t_early;
    do_reset;
    wb(WWDG_OFS_CFG, 1'b1, 32'h250);
    wb(WWDG_OFS_CTRL, 1'b1, 32'hFF);
    wb(WWDG_OFS_CTRL, 1'b1, 32'h7F);
    repeat (2) @(posedge clk_sys);
    check(32'(rst_cnt), 32'h1, "early refresh");
    wb(WWDG_OFS_STAT, 1'b0, 32'h0);
    check(rd, 32'h1, "no flag on early refresh");
    wb(WWDG_OFS_CTRL, 1'b0, 32'h0);
    check({31'h0, rd[7]}, 32'h1, "run cleared");
    wb(WWDG_OFS_CFG, 1'b1, 32'h050);
    wb(WWDG_OFS_CFG, 1'b0, 32'h0);
    check(rd, 32'h250, "enable cleared by write");
    bus_rst <= 1'b1;
    @(posedge clk_sys);
    bus_rst <= 1'b0;
    wb(WWDG_OFS_CFG, 1'b0, 32'h0);
    check(rd, 32'h050, "enable kept over bus reset");
    check({31'h0, early_warn_irq}, 32'h0, "irq without enable");
  endtask : t_early

  initial
  begin
    #200000;
    error_cnt++;
    summarize;
  end

  initial
  begin
    t_reset_vals;
    t_tick(2'd0);
    t_freeze;
    for (int i = 1; i < 4; i++)
      t_tick(2'(i));
    t_warn;
    t_early;
    summarize;
  end
endmodule : wwdg_core_bench
